// file: hdl/bcdg_pkg.sv
// Package of constants and carrier types for the commutation direction guard
package bcdg_pkg;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_PERIOD_PS = 4000;
  localparam int OSC_PERIOD_NS = 25000;
  localparam int OSC_CYCLES    = (OSC_PERIOD_NS * 1000) / CLK_PERIOD_PS;
  localparam int OSC_CNT_W     = 13;
  localparam logic [OSC_CNT_W-1:0] OSC_LAST = OSC_CNT_W'(OSC_CYCLES - 1);

  // ****************************************
  // Reset values and encodings
  // ****************************************
  localparam logic       DIR_RESET   = 1'b0;
  localparam logic [2:0] HS_OFF_N    = 3'h7;
  localparam logic [2:0] LS_OFF      = 3'h0;
  localparam logic [1:0] SHIFT_RESET = 2'h0;

  // Sensor code carrier
  typedef struct packed {
    logic c;
    logic b;
    logic a;
  } bcdg_sensor_s;

  // Drive command carrier
  typedef struct packed {
    logic [2:0] highSideN;
    logic [2:0] lowSide;
  } bcdg_drive_s;

endpackage

// file: hdl/bcdg_guard.sv
// Commutation decoder with direction reversal guard and drive blanking
`timescale 1ns/1ps
`default_nettype none
module bcdg_guard
(
  // Clock and reset
  input  wire logic                   ref_clk,
  input  wire logic                   rst,
  // Sensors and commands
  input  wire bcdg_pkg::bcdg_sensor_s shaftSensor,
  input  wire logic                   dirRequest,
  input  wire logic                   slowSpeed,
  input  wire logic                   pwmTrip,
  input  wire logic                   peakCurrentTrip,
  input  wire logic                   overCurrentTrip,
  input  wire logic                   overvoltageCoastIn,
  // Drives and status
  output var  bcdg_pkg::bcdg_drive_s  drive,
  output logic                        tachPulseOut,
  output logic                        softStartCmd,
  output logic                        oscTick
);
  import bcdg_pkg::*;

  // ****************************************
  // Internal signals
  // ****************************************
  // Oscillator period count
  logic [OSC_CNT_W-1:0] oscCnt_reg;

  // Direction path: latch, two-stage shifter, decoder direction
  logic                 dirLatch_reg;
  logic [1:0]           dirShift_reg;
  logic                 decodeDir;

  // Request level of the previous cycle, for the tach pulse
  logic                 dirReqPrev_reg;

  // PWM latch: set per period, cleared by comparator trips
  logic                 pwmLatch_reg;

  // Reversal guard terms
  logic                 latchMismatch;
  logic                 shiftInMismatch;
  logic                 shiftOutMismatch;
  logic                 inhibit;

  // Blanking terms
  logic                 pwmChop;
  logic                 faultBlank;
  logic                 blankAll;

  // Decoder result and per-phase next drive levels
  bcdg_drive_s          decoded;
  logic [2:0]           hsNext;
  logic [2:0]           lsNext;
  bcdg_drive_s          drive_next;

  // ****************************************
  // Oscillator period counter
  // ****************************************
  // Free-running count, wraps after one period
  // No clock enable: the strobe qualifies the period logic
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      oscCnt_reg <= '0;
    else if (oscCnt_reg == OSC_LAST)
      oscCnt_reg <= '0;
    else
      oscCnt_reg <= oscCnt_reg + 1'b1;
  end

  // Period end strobe, one cycle wide
  assign oscTick = (oscCnt_reg == OSC_LAST);

  // ****************************************
  // Direction latch and shifter
  // ****************************************
  // Latch follows request only at slow speed
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      dirLatch_reg <= DIR_RESET;
    else if (slowSpeed)
      dirLatch_reg <= dirRequest;
  end                                   // holds otherwise

  // Two-bit shifter on oscillator tick
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      dirShift_reg <= SHIFT_RESET;
    else if (oscTick)
      dirShift_reg <= {dirShift_reg[0], dirLatch_reg};
  end

  // Only the last stage reaches the decoder
  assign decodeDir = dirShift_reg[1];

  // ****************************************
  // Reversal guard
  // ****************************************
  // Drives stay off one to two periods per reversal
  // Request not yet taken by the clocked direction latch
  assign latchMismatch = slowSpeed && (dirRequest != dirLatch_reg);

  // Latch ahead of the first shifter stage
  assign shiftInMismatch = (dirLatch_reg != dirShift_reg[0]);

  // First stage ahead of the decoder's stage
  assign shiftOutMismatch = (dirShift_reg[0] != dirShift_reg[1]);

  // Any disagreement blanks all drives
  assign inhibit = latchMismatch || shiftInMismatch || shiftOutMismatch;

  // ****************************************
  // Tachometer pulse on direction toggle
  // ****************************************
  // Request level one cycle back
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      dirReqPrev_reg <= DIR_RESET;
    else
      dirReqPrev_reg <= dirRequest;
  end

  // One-cycle pulse per request change, any speed
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      tachPulseOut <= 1'b0;
    else
      tachPulseOut <= (dirRequest != dirReqPrev_reg);
  end

  // ****************************************
  // PWM latch
  // ****************************************
  // Set at period start, cleared by trips; clear wins
  // Starts clear, so drives wait for the first tick
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      pwmLatch_reg <= 1'b0;
    else if (pwmTrip || peakCurrentTrip)
      pwmLatch_reg <= 1'b0;
    else if (oscTick)
      pwmLatch_reg <= 1'b1;
  end

  // Cleared latch chops until the next period
  assign pwmChop = !pwmLatch_reg;

  // ****************************************
  // Fault handling
  // ****************************************
  // Soft-start request follows overcurrent
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      softStartCmd <= 1'b0;
    else
      softStartCmd <= overCurrentTrip;
  end

  // Overcurrent or over-voltage/coast hold drives off
  assign faultBlank = overCurrentTrip || overvoltageCoastIn;

  // Every reason to hold all six drives off
  assign blankAll = inhibit || pwmChop || faultBlank;

  // ****************************************
  // Six-step decoder
  // ****************************************
  // Valid 120-degree codes; 000 and 111 give no drive
  // Reverse direction inverts the code: high and low swap
  // Row order follows the forward rotation
  always_comb
  begin
    decoded = '{highSideN: HS_OFF_N, lowSide: LS_OFF};
    unique case ({shaftSensor.c, shaftSensor.b, shaftSensor.a} ^ {3{decodeDir}})
      3'h1: decoded = '{highSideN: 3'h6, lowSide: 3'h2};
      3'h3: decoded = '{highSideN: 3'h6, lowSide: 3'h4};
      3'h2: decoded = '{highSideN: 3'h5, lowSide: 3'h4};
      3'h6: decoded = '{highSideN: 3'h5, lowSide: 3'h1};
      3'h4: decoded = '{highSideN: 3'h3, lowSide: 3'h1};
      3'h5: decoded = '{highSideN: 3'h3, lowSide: 3'h2};
      default: decoded = '{highSideN: HS_OFF_N, lowSide: LS_OFF};
    endcase
  end

  // ****************************************
  // Per-phase blanking
  // ****************************************
  // Blanking releases both devices of a phase at once
  for (genvar ph = 0; ph < 3; ph++)
  begin : g_phase
    // High side released while blanked
    assign hsNext[ph] = blankAll ? HS_OFF_N[ph] : decoded.highSideN[ph];
    // Low side off while blanked
    assign lsNext[ph] = blankAll ? LS_OFF[ph] : decoded.lowSide[ph];
  end

  // Regroup the phases into one drive word
  assign drive_next = '{highSideN: hsNext, lowSide: lsNext};

  // ****************************************
  // Output register
  // ****************************************
  // Registered drive outputs; reset leaves every device off
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      drive <= '{highSideN: HS_OFF_N, lowSide: LS_OFF};
    else
      drive <= drive_next;
  end

endmodule
`default_nettype wire

// file: dv/bcdg_sensor_model.sv
// Shaft sensor model giving gray-coded positions
`timescale 1ns/1ps
`default_nettype none
module bcdg_sensor_model
  import bcdg_pkg::*;
(
  // Position select and sensor levels
  input  wire logic [2:0]        step,
  output var bcdg_pkg::bcdg_sensor_s shaftSensor
);
  // One sensor changes per step; steps 6 and 7 are faulty codes
  localparam logic [2:0] CODES [8] = '{3'h1, 3'h3, 3'h2, 3'h6, 3'h4, 3'h5, 3'h0, 3'h7};
  assign shaftSensor = CODES[step];
endmodule
`default_nettype wire

// file: dv/bcdg_guard_checker.sv
// Assertion checker for the commutation guard
`timescale 1ns/1ps
`default_nettype none
module bcdg_guard_checker
  import bcdg_pkg::*;
(
  // Clock and reset
  input wire logic                  ref_clk,
  input wire logic                  rst,
  // Direction and trip inputs
  input wire logic                  dirRequest,
  input wire logic                  slowSpeed,
  input wire logic                  pwmTrip,
  input wire logic                  peakCurrentTrip,
  input wire logic                  overCurrentTrip,
  input wire logic                  overvoltageCoastIn,
  // Design outputs
  input wire logic                  tachPulseOut,
  input wire logic                  softStartCmd,
  input wire logic                  oscTick,
  input wire bcdg_pkg::bcdg_drive_s drive
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  // Drive blanking and pulses
  a_ov_off: assert property (overvoltageCoastIn |=> drive == {HS_OFF_N, LS_OFF})
    else $error("drives on during coast");
  a_oc_off: assert property (overCurrentTrip |=> drive == {HS_OFF_N, LS_OFF})
    else $error("drives on during overcurrent");
  a_oc_soft: assert property (overCurrentTrip |=> softStartCmd)
    else $error("no soft start");
  a_tach_pulse: assert property ($changed(dirRequest) |=> tachPulseOut)
    else $error("no tach pulse");
  a_pwm_chop: assert property (pwmTrip ##1 !oscTick |=> drive.lowSide == LS_OFF)
    else $error("pwm trip not chopping");
  a_peak_chop: assert property (peakCurrentTrip ##1 !oscTick |=> drive.lowSide == LS_OFF)
    else $error("peak trip not chopping");
  a_one_pair: assert property ($onehot0(drive.lowSide) && $onehot0(~drive.highSideN)
    && (drive.lowSide & ~drive.highSideN) == 3'h0) else $error("bad phase pair");
  a_rev_inhibit: assert property (slowSpeed && $changed(dirRequest) |=>
    drive.lowSide == LS_OFF) else $error("drives on during reversal");
  // Main scenarios
  c_tick: cover property (oscTick);
  c_tach: cover property (tachPulseOut);
  c_soft: cover property (softStartCmd);
endmodule
bind bcdg_guard bcdg_guard_checker chk (.ref_clk(ref_clk), .rst(rst), .dirRequest(dirRequest),
  .slowSpeed(slowSpeed), .pwmTrip(pwmTrip), .peakCurrentTrip(peakCurrentTrip),
  .overCurrentTrip(overCurrentTrip), .overvoltageCoastIn(overvoltageCoastIn),
  .tachPulseOut(tachPulseOut), .softStartCmd(softStartCmd), .oscTick(oscTick), .drive(drive));
`default_nettype wire

// file: dv/tb_bldc_commutation_direction_guard.sv
// Self-checking bench for the commutation guard
`timescale 1ns/1ps
`default_nettype none
module tb_bldc_commutation_direction_guard;
  import bcdg_pkg::*;
  // ****************************************
  // Stimulus, design and tasks
  // ****************************************
  logic ref_clk = 1'b0, rst = 1'b1, dirRequest = 1'b0, slowSpeed = 1'b0;
  logic [3:0] trips = 4'h0;
  logic [2:0] step = 3'h0;
  bcdg_sensor_s shaftSensor;
  bcdg_drive_s drive;
  logic tachPulseOut, softStartCmd, oscTick;
  int nMismatch = 0, comparisons = 0, n;
  logic [5:0] expTab [6] = '{6'h32, 6'h34, 6'h2C, 6'h29, 6'h19, 6'h1A};
  always #2 ref_clk = ~ref_clk;
  bcdg_sensor_model model (.step(step), .shaftSensor(shaftSensor));
  bcdg_guard uut (.ref_clk(ref_clk), .rst(rst), .shaftSensor(shaftSensor),
    .dirRequest(dirRequest), .slowSpeed(slowSpeed), .pwmTrip(trips[0]),
    .peakCurrentTrip(trips[1]), .overCurrentTrip(trips[2]), .overvoltageCoastIn(trips[3]),
    .drive(drive), .tachPulseOut(tachPulseOut), .softStartCmd(softStartCmd), .oscTick(oscTick));
  task automatic check(input string what, input logic [5:0] seen, input logic [5:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      nMismatch++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge ref_clk);
    #1;
  endtask
  task automatic waitOsc;
    for (int i = 0; i < 7000 && oscTick !== 1'b1; i++) tick(1);
    tick(2);
  endtask
  // All positions in one direction, ending at position 0
  task automatic sweep(input int d);
    for (int i = 7; i >= 0; i--)
    begin
      @(posedge ref_clk) step <= 3'(i);
      tick(2);
      check("drive", drive, i < 6 ? expTab[(i + 3 * d) % 6] : 6'h38);
    end
  endtask
  // Each trip blanks drives; chop holds until the next period
  task automatic tripTest;
    for (int k = 0; k < 4; k++)
    begin
      @(posedge ref_clk) trips <= 4'h1 << k;
      tick(3);
      check("lowSide", 6'(drive.lowSide), 6'(LS_OFF));
      check("softStart", 6'(softStartCmd), 6'(k == 2));
      @(posedge ref_clk) trips <= 4'h0;
      tick(3);
      if (k < 2) check("chop", 6'(drive.lowSide), 6'(LS_OFF));
      waitOsc();
      check("driveBack", drive, expTab[3]);
    end
  endtask
  task automatic wrapUp;
    $display("TB: mismatches %0d comparisons %0d", nMismatch, comparisons);
    if (nMismatch == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // Ticks one oscillator period apart; call right after waitOsc
  task automatic oscPeriod;
    for (n = 2; n < 7000 && oscTick !== 1'b1; n++) tick(1);
    check("oscPeriod", 6'(n == OSC_CYCLES), 6'h1);
  endtask
  // Fast spin: one tach pulse per change, direction held
  task automatic fastHold;
    @(posedge ref_clk) dirRequest <= 1'b1;
    tick(1);
    check("tach", 6'(tachPulseOut), 6'h1);
    tick(1);
    check("tachEnd", 6'(tachPulseOut), 6'h0);
    waitOsc();
    waitOsc();
    sweep(0);
  endtask
  // Slow spin: reversal blanks drives one to two periods
  task automatic slowReverse;
    @(posedge ref_clk) dirRequest <= 1'b0;
    @(posedge ref_clk) slowSpeed <= 1'b1;
    @(posedge ref_clk) dirRequest <= 1'b1;
    tick(2);
    for (n = 0; n < 20000 && drive.lowSide === LS_OFF; n++) tick(1);
    check("delay", 6'(n > OSC_CYCLES - 4 && n < 2 * OSC_CYCLES + 4), 6'h1);
  endtask
  // Main sequence
  initial
  begin
    tick(4);
    @(posedge ref_clk) rst <= 1'b0;
    waitOsc();
    oscPeriod();
    sweep(0);
    fastHold();
    slowReverse();
    sweep(1);
    tripTest();
    wrapUp();
  end
  // Watchdog
  initial
  begin
    repeat (90000) @(posedge ref_clk);
    nMismatch++;
    wrapUp();
  end
endmodule
`default_nettype wire
